/* hw/charge_seq_pkg.sv */
`default_nettype none
package charge_seq_pkg;

    // time-limit counter
    localparam int TIMER_STAGES = 22;
    localparam int TRICKLE_LIMIT_BIT = 19;
    localparam logic [3:0] TRICKLE_EXIT_PERIODS = 4'hf;
    localparam logic [3:0] ABOVE_CNT_RESET = 4'h0;
    localparam logic [TIMER_STAGES-1:0] TIMER_RESET = 22'h000000;

    // register port
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    localparam logic [ADDR_WIDTH-1:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] REG_IRQ_MASK = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] REG_MODE = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] REG_TIMER = 4'hc;

    // interrupt events
    localparam int EV_WIDTH = 4;
    localparam int EV_COMPLETE = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_REMOVED = 2;
    localparam int EV_TEMP = 3;
    localparam logic [EV_WIDTH-1:0] IRQ_MASK_RESET = 4'h0;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_TRICKLE = 3'h1,
        ST_CC = 3'h3,
        ST_CV = 3'h2,
        ST_INHIBIT = 3'h6,
        ST_FAULT = 3'h7
    } mode_type;

    // comparator results and pins from the analog side
    typedef struct packed {
        logic enable;
        logic adapter_present;
        logic timeout_limit_enable_n;
        logic batt_removed;
        logic temp_in_window;
        logic current_at_eoc;
        logic vbat_above_trickle_exit;
        logic vbat_below_recharge;
        logic vbat_at_termination;
    } comp_type;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        mode_type mode;
        logic tmo_latched;
        logic removed_fault;
        logic temp_hold;
        logic [3:0] above_cnt;
        logic [EV_WIDTH-1:0] irq_status;
        logic [EV_WIDTH-1:0] irq_mask;
        logic [DATA_WIDTH-1:0] rdata;
        logic irq;
        logic status_oe;
        logic fault_oe;
        logic charge_on;
        logic ref_tenth;
    } seq_state_type;

endpackage
`default_nettype wire

/* hw/comp_sync.sv */
`default_nettype none
module comp_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // raw and synchronised comparators
    input wire charge_seq_pkg::comp_type raw,
    output charge_seq_pkg::comp_type synced
);
    typedef struct packed {
        charge_seq_pkg::comp_type meta;
        charge_seq_pkg::comp_type stable;
    } sync_state_type;

    sync_state_type q;
    sync_state_type d;

    always_comb begin
        d.meta = raw;
        d.stable = q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign synced = q.stable;
endmodule // comp_sync
`default_nettype wire

/* hw/charge_timer.sv */
`default_nettype none
module charge_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic advance,
    // state
    output logic [charge_seq_pkg::TIMER_STAGES-1:0] count,
    output logic expired,
    output logic eighth_expired
);
    typedef struct packed {
        logic [charge_seq_pkg::TIMER_STAGES-1:0] cnt;
        logic full;
    } timer_state_type;

    timer_state_type q;
    timer_state_type d;

    always_comb begin
        d = q;
        if (clear) begin
            d.cnt = charge_seq_pkg::TIMER_RESET;
            d.full = 1'b0;
        end else if (advance) begin
            if (&q.cnt) begin
                d.full = 1'b1;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign expired = q.full;
    // one eighth of the full span is reached when any top three bits is set
    assign eighth_expired =
        |q.cnt[charge_seq_pkg::TIMER_STAGES-1:charge_seq_pkg::TRICKLE_LIMIT_BIT];
endmodule // charge_timer
`default_nettype wire

/* hw/charge_cycle_sequencer.sv */
`default_nettype none
// How it works
// - leave constant current for constant voltage at termination voltage
// - clear time-limit counter on entering constant current
// - counter past limit latches timeout fault, stops charging
// - timeout limit pin low disables limit in CC and CV
// - in CC and CV status driven low, fault released
// - in CV, current at end-of-charge level completes the cycle
// - counter runs on through CV; one limit covers CC and CV
// - completed cycle enters inhibit, watching battery voltage
// - inhibit restarts a cycle when battery drops below recharge level
// - inhibit releases both status and fault
// - temperature out of window halts charging, freezes counter
// - any fault drives fault low and releases status
// - enable low or adapter absent forces standby, no charging
// - trickle selects tenth reference, constant current full setting
// - time limit from 22-stage counter, one step per oscillator period
// - trickle exit after 15 periods above; trickle limit one eighth
// - timeout fault holds until power cycles or enable toggles
// - battery removal signals fault; reinsertion starts new cycle unless a timeout fault is latched
module charge_cycle_sequencer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // analog comparators, one oscillator period per tick
    input wire charge_seq_pkg::comp_type comp_raw,
    input wire logic osc_tick,
    // register port
    input wire charge_seq_pkg::bus_req_type bus_req,
    output logic [charge_seq_pkg::DATA_WIDTH-1:0] bus_rdata,
    // open-drain indications, loop control
    output logic status_out,
    output logic status_oe,
    output logic fault_out,
    output logic fault_oe,
    output logic charge_on,
    output logic loop_ref_tenth,
    output logic irq
);
    charge_seq_pkg::comp_type s;
    charge_seq_pkg::seq_state_type q;
    charge_seq_pkg::seq_state_type d;
    logic [charge_seq_pkg::TIMER_STAGES-1:0] tmr_count;
    logic tmr_expired;
    logic tmr_eighth;
    logic tmr_clear;
    logic tmr_advance;
    logic powered;
    logic temp_bad;
    logic go;
    logic lim_en;
    logic [charge_seq_pkg::EV_WIDTH-1:0] ev;

    comp_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .raw(comp_raw),
        .synced(s)
    );

    charge_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(tmr_clear),
        .advance(tmr_advance),
        .count(tmr_count),
        .expired(tmr_expired),
        .eighth_expired(tmr_eighth)
    );

    function automatic logic is_charging(charge_seq_pkg::mode_type m);
        is_charging = (m == charge_seq_pkg::ST_TRICKLE) ||
            (m == charge_seq_pkg::ST_CC) || (m == charge_seq_pkg::ST_CV);
    endfunction

    function automatic logic is_fast(charge_seq_pkg::mode_type m);
        is_fast = (m == charge_seq_pkg::ST_CC) ||
            (m == charge_seq_pkg::ST_CV);
    endfunction

    // the limit pin is active high in effect: pulled low, no limit
    assign lim_en = s.timeout_limit_enable_n;
    assign powered = s.enable && s.adapter_present;
    // removal overrides the window result, the thermistor is gone
    assign temp_bad = !s.temp_in_window && !s.batt_removed;
    assign go = powered && !s.batt_removed && !temp_bad;

    always_comb begin
        d = q;
        ev = '0;
        tmr_clear = 1'b0;
        tmr_advance = 1'b0;
        d.temp_hold = 1'b0;
        if (!powered) begin
            d.mode = charge_seq_pkg::ST_STANDBY;
            // leaving for standby releases the latch
            d.tmo_latched = 1'b0;
            d.removed_fault = 1'b0;
        end else if (s.batt_removed && q.mode != charge_seq_pkg::ST_FAULT) begin
            d.mode = charge_seq_pkg::ST_FAULT;
            d.removed_fault = 1'b1;
            ev[charge_seq_pkg::EV_REMOVED] = 1'b1;
        end else if (temp_bad && q.mode != charge_seq_pkg::ST_STANDBY &&
                     q.mode != charge_seq_pkg::ST_FAULT) begin
            d.temp_hold = 1'b1;
        end else begin
            case (q.mode)
                charge_seq_pkg::ST_STANDBY: begin
                    d.mode = charge_seq_pkg::ST_TRICKLE;
                    d.above_cnt = charge_seq_pkg::ABOVE_CNT_RESET;
                    tmr_clear = 1'b1;
                end
                charge_seq_pkg::ST_TRICKLE: begin
                    tmr_advance = osc_tick;
                    // trickle limit applies regardless of the pin
                    if (tmr_eighth) begin
                        d.mode = charge_seq_pkg::ST_FAULT;
                        d.tmo_latched = 1'b1;
                        ev[charge_seq_pkg::EV_TIMEOUT] = 1'b1;
                    end else if (osc_tick) begin
                        if (!s.vbat_above_trickle_exit) begin
                            d.above_cnt = charge_seq_pkg::ABOVE_CNT_RESET;
                        end else if (q.above_cnt ==
                                     charge_seq_pkg::TRICKLE_EXIT_PERIODS - 4'h1) begin
                            d.mode = charge_seq_pkg::ST_CC;
                            d.above_cnt = charge_seq_pkg::ABOVE_CNT_RESET;
                            tmr_clear = 1'b1;
                        end else begin
                            d.above_cnt = q.above_cnt + 4'h1;
                        end
                    end
                end
                charge_seq_pkg::ST_CC, charge_seq_pkg::ST_CV: begin
                    tmr_advance = osc_tick;
                    if (tmr_expired && lim_en) begin
                        d.mode = charge_seq_pkg::ST_FAULT;
                        d.tmo_latched = 1'b1;
                        ev[charge_seq_pkg::EV_TIMEOUT] = 1'b1;
                    end else if (q.mode == charge_seq_pkg::ST_CC) begin
                        // no clear on the way into CV
                        if (s.vbat_at_termination) begin
                            d.mode = charge_seq_pkg::ST_CV;
                        end
                    end else if (s.current_at_eoc) begin
                        d.mode = charge_seq_pkg::ST_INHIBIT;
                        ev[charge_seq_pkg::EV_COMPLETE] = 1'b1;
                    end
                end
                charge_seq_pkg::ST_INHIBIT: begin
                    if (s.vbat_below_recharge) begin
                        d.mode = charge_seq_pkg::ST_TRICKLE;
                        d.above_cnt = charge_seq_pkg::ABOVE_CNT_RESET;
                        tmr_clear = 1'b1;
                    end
                end
                charge_seq_pkg::ST_FAULT: begin
                    // a timeout latch stays put
                    // wait for the pack to return, else fault and trickle
                    // would alternate every cycle while it is still out
                    if (q.removed_fault && !q.tmo_latched &&
                        !s.batt_removed) begin
                        d.mode = charge_seq_pkg::ST_TRICKLE;
                        d.removed_fault = 1'b0;
                        d.above_cnt = charge_seq_pkg::ABOVE_CNT_RESET;
                        tmr_clear = 1'b1;
                    end
                end
                default: begin
                    d.mode = charge_seq_pkg::ST_STANDBY;
                end
            endcase
        end

        if (d.temp_hold && !q.temp_hold) begin
            ev[charge_seq_pkg::EV_TEMP] = 1'b1;
        end

        // fault pulls fault low, status released
        d.fault_oe = (d.mode == charge_seq_pkg::ST_FAULT) || d.temp_hold;
        d.status_oe = is_charging(d.mode) && !d.fault_oe;
        d.charge_on = d.status_oe;
        d.ref_tenth = (d.mode == charge_seq_pkg::ST_TRICKLE);

        // write one to clear; a new event in the same cycle still lands
        if (bus_req.wr && bus_req.addr == charge_seq_pkg::REG_IRQ_STATUS) begin
            d.irq_status = q.irq_status &
                ~bus_req.wdata[charge_seq_pkg::EV_WIDTH-1:0];
        end
        d.irq_status = d.irq_status | ev;
        if (bus_req.wr && bus_req.addr == charge_seq_pkg::REG_IRQ_MASK) begin
            d.irq_mask = bus_req.wdata[charge_seq_pkg::EV_WIDTH-1:0];
        end
        d.irq = |(d.irq_status & d.irq_mask);

        d.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                charge_seq_pkg::REG_IRQ_STATUS:
                    d.rdata[charge_seq_pkg::EV_WIDTH-1:0] = q.irq_status;
                charge_seq_pkg::REG_IRQ_MASK:
                    d.rdata[charge_seq_pkg::EV_WIDTH-1:0] = q.irq_mask;
                charge_seq_pkg::REG_MODE:
                    d.rdata[5:0] = {q.temp_hold, q.removed_fault,
                                    q.tmo_latched, q.mode};
                charge_seq_pkg::REG_TIMER:
                    d.rdata[charge_seq_pkg::TIMER_STAGES-1:0] = tmr_count;
                default:
                    d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.mode <= charge_seq_pkg::ST_STANDBY;
            q.irq_mask <= charge_seq_pkg::IRQ_MASK_RESET;
            // power-on state shows fault low, status released
            q.fault_oe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // open-drain pins only ever pull low
    assign status_out = 1'b0;
    assign fault_out = 1'b0;
    assign status_oe = q.status_oe;
    assign fault_oe = q.fault_oe;
    assign charge_on = q.charge_on;
    assign loop_ref_tenth = q.ref_tenth;
    assign irq = q.irq;
    assign bus_rdata = q.rdata;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_cc_to_cv;
        q.mode == charge_seq_pkg::ST_CC && go && s.vbat_at_termination &&
        !(tmr_expired && lim_en) |=> q.mode == charge_seq_pkg::ST_CV;
    endproperty
    a_cc_to_cv: assert property (p_cc_to_cv)
        else $error("termination level did not move CC to CV");

    property p_cc_clear;
        q.mode == charge_seq_pkg::ST_TRICKLE ##1
        q.mode == charge_seq_pkg::ST_CC |-> tmr_count == '0;
    endproperty
    a_cc_clear: assert property (p_cc_clear)
        else $error("counter not cleared on entering CC");

    property p_timeout;
        is_fast(q.mode) && go && tmr_expired && lim_en |=>
        q.mode == charge_seq_pkg::ST_FAULT && q.tmo_latched ##1 !charge_on;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("expired limit did not latch a fault");

    property p_no_limit;
        is_fast(q.mode) && go && !lim_en |=>
        q.mode != charge_seq_pkg::ST_FAULT;
    endproperty
    a_no_limit: assert property (p_no_limit)
        else $error("fault raised with limit disabled");

    property p_fast_pins;
        is_fast(q.mode) && !q.temp_hold |-> status_oe && !fault_oe;
    endproperty
    a_fast_pins: assert property (p_fast_pins)
        else $error("wrong indications during fast charge");

    property p_complete;
        q.mode == charge_seq_pkg::ST_CV && go && s.current_at_eoc &&
        !(tmr_expired && lim_en) |=> q.mode == charge_seq_pkg::ST_INHIBIT
        && q.irq_status[charge_seq_pkg::EV_COMPLETE];
    endproperty
    a_complete: assert property (p_complete)
        else $error("end-of-charge current did not complete cycle");

    property p_cv_keeps_count;
        q.mode == charge_seq_pkg::ST_CC ##1 q.mode == charge_seq_pkg::ST_CV
        |-> tmr_count >= $past(tmr_count);
    endproperty
    a_cv_keeps_count: assert property (p_cv_keeps_count)
        else $error("counter restarted on entering CV");

    property p_recharge;
        q.mode == charge_seq_pkg::ST_INHIBIT && go && s.vbat_below_recharge
        |=> q.mode == charge_seq_pkg::ST_TRICKLE && status_oe;
    endproperty
    a_recharge: assert property (p_recharge)
        else $error("recharge level did not restart charging");

    property p_inhibit_pins;
        q.mode == charge_seq_pkg::ST_INHIBIT && !q.temp_hold |->
        !status_oe && !fault_oe;
    endproperty
    a_inhibit_pins: assert property (p_inhibit_pins)
        else $error("inhibit indications wrong");

    property p_temp_freeze;
        is_charging(q.mode) && powered && temp_bad && !s.batt_removed |=>
        $stable(tmr_count) && $stable(q.mode) && !charge_on;
    endproperty
    a_temp_freeze: assert property (p_temp_freeze)
        else $error("charging or counter moved out of window");

    property p_fault_pins;
        q.mode == charge_seq_pkg::ST_FAULT |-> fault_oe && !status_oe;
    endproperty
    a_fault_pins: assert property (p_fault_pins)
        else $error("fault indications wrong");

    property p_standby;
        !powered |=> q.mode == charge_seq_pkg::ST_STANDBY && !charge_on;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby not entered");

    property p_tenth;
        loop_ref_tenth == (q.mode == charge_seq_pkg::ST_TRICKLE);
    endproperty
    a_tenth: assert property (p_tenth)
        else $error("reference selection does not follow mode");

    property p_latched;
        q.mode == charge_seq_pkg::ST_FAULT && q.tmo_latched && powered
        |=> q.mode == charge_seq_pkg::ST_FAULT;
    endproperty
    a_latched: assert property (p_latched)
        else $error("timeout fault released while powered");

    property p_removal;
        powered && s.batt_removed |=> q.mode == charge_seq_pkg::ST_FAULT
        && fault_oe;
    endproperty
    a_removal: assert property (p_removal)
        else $error("removal did not show a fault");

    property p_sync;
        !$past(rst, 2) |-> s == $past(comp_raw, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchroniser depth not two");

endmodule // charge_cycle_sequencer
`default_nettype wire

/* verification/charge_pack_model.sv */
`default_nettype none
module charge_pack_model #(
    parameter logic [7:0] EXIT_LEVEL = 8'h28,
    parameter logic [7:0] RECHARGE_LEVEL = 8'hb4,
    parameter logic [7:0] TERM_LEVEL = 8'hc8
) (
    // clock and oscillator period
    input wire logic ref_clk,
    input wire logic osc_tick,
    // loop control from the sequencer
    input wire logic charge_on,
    input wire logic loop_ref_tenth,
    // scenario controls
    input wire logic drain,
    input wire logic spike,
    // comparator levels
    output logic above_exit,
    output logic below_recharge,
    output logic at_term,
    output logic at_eoc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] vbat_q = 8'h00;
    logic [3:0] taper_q = 4'hf;
    wire logic [7:0] vbat_up = vbat_q + (loop_ref_tenth ? 8'h01 : 8'h0a);

    always @(posedge ref_clk) begin
        if (osc_tick && drain) begin
            vbat_q <= (vbat_q > 8'h02) ? vbat_q - 8'h02 : 8'h00;
        end else if (osc_tick && charge_on) begin
            vbat_q <= (vbat_up > TERM_LEVEL) ? TERM_LEVEL : vbat_up;
        end
        if (!at_term) begin
            taper_q <= 4'hf;
        end else if (osc_tick && charge_on && taper_q != 4'h0) begin
            taper_q <= taper_q - 4'h1;
        end
    end

    // spike mimics a transient on the pack terminals
    assign above_exit = spike || (vbat_q >= EXIT_LEVEL);
    assign below_recharge = (vbat_q < RECHARGE_LEVEL);
    assign at_term = (vbat_q >= TERM_LEVEL);
    // current tapers to end of charge
    assign at_eoc = at_term && (taper_q == 4'h0);
endmodule // charge_pack_model
`default_nettype wire

/* verification/charge_cycle_sequencer_test.sv */
`default_nettype none
module charge_cycle_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic osc_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic en = 1'b0, ad = 1'b1, lim = 1'b1, rem = 1'b0, tw = 1'b1;
    logic drain = 1'b0, spike = 1'b0;
    logic above_exit, below_recharge, at_term, at_eoc;
    charge_seq_pkg::comp_type comp_raw;
    charge_seq_pkg::bus_req_type bus_req = '0;
    logic [31:0] bus_rdata;
    logic status_out, status_oe, fault_out, fault_oe;
    logic charge_on, loop_ref_tenth, irq;
    int n_errors = 0;
    int compares = 0;
    // open-drain pins with their pull-ups
    wire logic status_pin = status_oe ? status_out : 1'b1;
    wire logic fault_pin = fault_oe ? fault_out : 1'b1;

    assign comp_raw = '{enable: en, adapter_present: ad,
        timeout_limit_enable_n: lim, batt_removed: rem,
        temp_in_window: tw, current_at_eoc: at_eoc,
        vbat_above_trickle_exit: above_exit,
        vbat_below_recharge: below_recharge,
        vbat_at_termination: at_term};

    charge_cycle_sequencer dut (
        .ref_clk(ref_clk), .rst(rst), .comp_raw(comp_raw),
        .osc_tick(osc_tick), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .status_out(status_out), .status_oe(status_oe),
        .fault_out(fault_out), .fault_oe(fault_oe),
        .charge_on(charge_on), .loop_ref_tenth(loop_ref_tenth), .irq(irq)
    );

    charge_pack_model pack (
        .ref_clk(ref_clk), .osc_tick(osc_tick), .charge_on(charge_on),
        .loop_ref_tenth(loop_ref_tenth), .drain(drain), .spike(spike),
        .above_exit(above_exit), .below_recharge(below_recharge),
        .at_term(at_term), .at_eoc(at_eoc)
    );

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // one oscillator period every four clocks keeps the run short
    always @(posedge ref_clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        osc_tick <= (tick_cnt == 2'h3);
    end

    function automatic logic [1:0] pins_for(input charge_seq_pkg::mode_type m);
        case (m)
            charge_seq_pkg::ST_TRICKLE, charge_seq_pkg::ST_CC,
            charge_seq_pkg::ST_CV: pins_for = 2'b01;
            charge_seq_pkg::ST_FAULT: pins_for = 2'b10;
            default: pins_for = 2'b11;
        endcase
    endfunction

    function automatic logic [31:0] mode_word(input logic hold,
        input logic gone, input charge_seq_pkg::mode_type m);
        return {26'h0, hold, gone, 1'b0, m};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic chk_pins(input charge_seq_pkg::mode_type m);
        check({30'h0, status_pin, fault_pin}, {30'h0, pins_for(m)});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        @(posedge ref_clk);
        d = bus_rdata;
    endtask

    task automatic wait_mode(input charge_seq_pkg::mode_type m);
        logic [31:0] d;
        d = 32'hffff_ffff;
        for (int i = 0; i < 500 && d[2:0] !== m; i++) begin
            rd(charge_seq_pkg::REG_MODE, d);
        end
        check({29'h0, d[2:0]}, {29'h0, m});
    endtask

    task automatic conclude;
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        $display("unexpected at %0t: watchdog ran out", $time);
        conclude();
    end

    initial begin
        logic [31:0] d, t1;
        void'($urandom(29));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({charge_on, irq}, 2'b00);
        wr(4'h6, 32'hffff_ffff);
        rd(charge_seq_pkg::REG_IRQ_MASK, d);
        check(d, 32'h0);
        rd(4'h2, d);
        check(d, 32'h0);
        $display("test reset done");
        en <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(charge_on, 1'b0);
        @(posedge ref_clk);
        check({charge_on, loop_ref_tenth}, 2'b11);
        chk_pins(charge_seq_pkg::ST_TRICKLE);
        // fourteen periods above the exit level must not leave trickle
        spike <= 1'b1;
        repeat (56) @(posedge ref_clk);
        spike <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check(loop_ref_tenth, 1'b1);
        wait_mode(charge_seq_pkg::ST_CC);
        rd(charge_seq_pkg::REG_TIMER, d);
        check({31'h0, d < 32'h3}, 32'h1);
        chk_pins(charge_seq_pkg::ST_CC);
        $display("test trickle done");
        tw <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check(charge_on, 1'b0);
        chk_pins(charge_seq_pkg::ST_FAULT);
        rd(charge_seq_pkg::REG_TIMER, t1);
        repeat (20) @(posedge ref_clk);
        rd(charge_seq_pkg::REG_TIMER, d);
        check(d, t1);
        rd(charge_seq_pkg::REG_MODE, d);
        check(d, mode_word(1'b1, 1'b0, charge_seq_pkg::ST_CC));
        tw <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({charge_on, loop_ref_tenth}, 2'b10);
        wait_mode(charge_seq_pkg::ST_CV);
        chk_pins(charge_seq_pkg::ST_CV);
        rd(charge_seq_pkg::REG_TIMER, d);
        check({31'h0, d >= t1 && d > 32'h4}, 32'h1);
        $display("test hold done");
        wait_mode(charge_seq_pkg::ST_INHIBIT);
        chk_pins(charge_seq_pkg::ST_INHIBIT);
        check(charge_on, 1'b0);
        rd(charge_seq_pkg::REG_IRQ_STATUS, d);
        check(d, 32'h9);
        check(irq, 1'b0);
        wr(charge_seq_pkg::REG_IRQ_MASK, 32'h1);
        @(posedge ref_clk);
        check(irq, 1'b1);
        wr(charge_seq_pkg::REG_IRQ_STATUS, 32'h1);
        @(posedge ref_clk);
        check(irq, 1'b0);
        rd(charge_seq_pkg::REG_IRQ_STATUS, d);
        check(d, 32'h8);
        drain <= 1'b1;
        wait_mode(charge_seq_pkg::ST_TRICKLE);
        drain <= 1'b0;
        $display("test inhibit done");
        rem <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk_pins(charge_seq_pkg::ST_FAULT);
        rd(charge_seq_pkg::REG_MODE, d);
        check(d, mode_word(1'b0, 1'b1, charge_seq_pkg::ST_FAULT));
        rem <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(charge_seq_pkg::REG_MODE, d);
        check(d, mode_word(1'b0, 1'b0, charge_seq_pkg::ST_TRICKLE));
        $display("test removal done");
        // draining keeps the pack from completing while power flips
        drain <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            en <= 1'($urandom);
            ad <= 1'($urandom);
            lim <= 1'($urandom);
            repeat (6) @(posedge ref_clk);
            check(charge_on, en & ad);
            chk_pins(en & ad ? charge_seq_pkg::ST_TRICKLE
                : charge_seq_pkg::ST_STANDBY);
        end
        $display("test standby done");
        conclude();
    end
endmodule // charge_cycle_sequencer_test
`default_nettype wire
